// ### inc/frsb_pkg.sv
// Purpose: shared constants and types of the fault response and status bank
// Assumes: 10 MHz clock, command port already decoded from the serial bus
// Notes: status flags are kept as one sticky vector indexed by the F_ names
package frsb_pkg;
    // command codes
    localparam logic [7:0] CMD_IN_UV_RESP = 8'h5a;
    localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
    localparam logic [7:0] CMD_OP_LIMIT = 8'h68;
    localparam logic [7:0] CMD_OP_RESP = 8'h69;
    localparam logic [7:0] CMD_SUMMARY = 8'h78;
    localparam logic [7:0] CMD_EXTENDED = 8'h79;
    localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
    // response codes, only these two are implemented
    localparam logic [7:0] RESP_IGNORE = 8'h00;
    localparam logic [7:0] RESP_LATCH = 8'h80;
    // over-power limit layout
    localparam int OP_EXP_LSB = 11;
    localparam logic [4:0] OP_EXP_VAL = 5'h02;
    localparam int OP_WATT_SHIFT = 2;
    // reset values
    localparam logic [7:0] RST_IN_UV_RESP = 8'h80;
    localparam logic [7:0] RST_OP_RESP = 8'h80;
    localparam logic [7:0] RST_TON = 8'h00;
    localparam logic [9:0] RST_OP_MANT = 10'h3ff;
    // turn-on delay step timing
    localparam int TON_STEP_US = 500;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TON_STEP_CYC = (TON_STEP_US * 1000) / CLK_PERIOD_NS;
    localparam int SUB_W = 16;
    // summary and extended bit positions
    localparam int B_BUSY = 7;
    localparam int B_OFF = 6;
    localparam int B_VOUT_OV = 5;
    localparam int B_IOUT_OC = 4;
    localparam int B_VIN_UV = 3;
    localparam int B_TEMP = 2;
    localparam int B_CML = 1;
    localparam int B_OTHER = 0;
    localparam int BW_VOUT = 15;
    localparam int BW_IOUT = 14;
    localparam int BW_INPUT = 13;
    localparam int BW_MFR = 12;
    localparam int BV_OV = 7;
    localparam int BV_UV = 4;
    localparam int BV_MAX = 3;
    // sticky flag indices
    localparam int F_BUSY = 0;
    localparam int F_VOUT_OV = 1;
    localparam int F_IOUT_OC = 2;
    localparam int F_VIN_UV = 3;
    localparam int F_TEMP = 4;
    localparam int F_CML = 5;
    localparam int F_OTHER = 6;
    localparam int F_VOUT_UV = 7;
    localparam int F_VOUT_MAX = 8;
    localparam int F_POUT_OP = 9;
    localparam int F_IOUT_WARN = 10;
    localparam int F_INPUT = 11;
    localparam int F_MFR = 12;
    localparam int NFLAG = 13;
    // output power state
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_ON = 2'b10,
        PWR_TRIP = 2'b11
    } frsb_pwr_e;
endpackage

// ### inc/frsb_ton_if.sv
// Purpose: link between the bank and its turn-on delay timer
// Assumes: single clock domain
// Notes: run held high for the whole wait, done is a level
interface frsb_ton_if;
    logic run;
    logic bypass;
    logic [7:0] steps;
    logic done;
    modport ctl (output run, output bypass, output steps, input done);
    modport tmr (input run, input bypass, input steps, output done);
endinterface

// ### logic/frsb_ton_timer.sv
// Purpose: counts turn-on delay in steps of one delay quantum
// Assumes: steps sampled while run is low, then held
// Notes: dropping run aborts the wait at once
module frsb_ton_timer #(
    parameter int STEP_CYC = frsb_pkg::TON_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    frsb_ton_if.tmr ton
);
    typedef struct packed {
        logic [7:0] steps;
        logic [frsb_pkg::SUB_W-1:0] sub;
        logic done;
    } frsb_tmr_s;

    localparam logic [frsb_pkg::SUB_W-1:0] SUB_LAST = frsb_pkg::SUB_W'(STEP_CYC - 1);

    frsb_tmr_s q, d;

    // reload while idle, count down one step per quantum while running
    always_comb begin
        d = q;
        if (!ton.run) begin
            d.steps = ton.steps;
            d.sub = '0;
            d.done = 1'b0;
        end else if (!q.done) begin
            if (ton.bypass || q.steps == 8'h00) begin
                d.done = 1'b1;
            end else if (q.sub == SUB_LAST) begin
                d.sub = '0;
                d.steps = q.steps - 8'h01;
            end else begin
                d.sub = q.sub + frsb_pkg::SUB_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ton.done = q.done;
endmodule

// ### logic/frsb_top.sv
// Purpose: fault response, limit, turn-on delay and status registers
// Assumes: command port carries one decoded bus transaction per cmd_valid
// Notes: writing ones to a status register clears those flags, save that summary bit 0 leaves vout uv and vout max set
module frsb_top #(
    parameter int TON_STEP_CYCLES = frsb_pkg::TON_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    input wire logic en_cmd,
    input wire logic en_pin,
    input wire logic en_group,
    input wire logic share_member,
    input wire logic [11:0] pout_watts,
    input wire logic busy_evt,
    input wire logic vout_ov_evt,
    input wire logic vout_uv_evt,
    input wire logic vout_max_evt,
    input wire logic iout_oc_evt,
    input wire logic iout_warn_evt,
    input wire logic vin_uv_evt,
    input wire logic input_evt,
    input wire logic temp_evt,
    input wire logic cml_evt,
    input wire logic mfr_evt,
    input wire logic other_evt,
    output logic vout_enable,
    output logic fault_alert_line_o,
    output logic fault_alert_line_oe
);
    typedef struct packed {
        frsb_pkg::frsb_pwr_e state;
        logic [7:0] in_uv_resp;
        logic [7:0] ton;
        logic [9:0] op_mant;
        logic [7:0] op_resp;
        logic [frsb_pkg::NFLAG-1:0] flags;
        logic rsp_valid;
        logic [15:0] rdata;
        logic vout_en;
        logic alert_o;
        logic alert_oe;
    } frsb_state_s;

    frsb_state_s q, d;
    frsb_ton_if ton ();

    logic wr;
    logic rd;
    logic known;
    logic bad_data;
    logic op_over;
    logic uv_trip;
    logic op_trip;
    logic enable;
    logic [12:0] op_watts;
    logic [frsb_pkg::NFLAG-1:0] ev;
    logic [frsb_pkg::NFLAG-1:0] clr;
    logic [frsb_pkg::NFLAG-1:0] flag_nx;
    logic [7:0] summary;
    logic [15:0] extended;
    logic [7:0] vflags;

    // command decode
    assign wr = cmd_valid && cmd_write;
    assign rd = cmd_valid && !cmd_write;
    assign known = cmd_code == frsb_pkg::CMD_IN_UV_RESP || cmd_code == frsb_pkg::CMD_TURN_ON_DELAY
        || cmd_code == frsb_pkg::CMD_OP_LIMIT || cmd_code == frsb_pkg::CMD_OP_RESP
        || cmd_code == frsb_pkg::CMD_SUMMARY || cmd_code == frsb_pkg::CMD_EXTENDED
        || cmd_code == frsb_pkg::CMD_VOUT_FLAGS;

    // refused data: unsupported response code or wrong power exponent
    always_comb begin
        bad_data = 1'b0;
        if (wr && (cmd_code == frsb_pkg::CMD_IN_UV_RESP || cmd_code == frsb_pkg::CMD_OP_RESP)) begin
            bad_data = cmd_wdata[7:0] != frsb_pkg::RESP_IGNORE
                && cmd_wdata[7:0] != frsb_pkg::RESP_LATCH;
        end else if (wr && cmd_code == frsb_pkg::CMD_OP_LIMIT) begin
            bad_data = cmd_wdata[15:frsb_pkg::OP_EXP_LSB] != frsb_pkg::OP_EXP_VAL;
        end
    end

    // over-power compare in watts, limit lsb is four watts
    assign op_watts = {1'b0, q.op_mant, 2'b00};
    assign op_over = {1'b0, pout_watts} > op_watts;

    // only the latch code trips the output, ignore keeps regulating
    assign uv_trip = vin_uv_evt && q.in_uv_resp == frsb_pkg::RESP_LATCH;
    assign op_trip = op_over && q.op_resp == frsb_pkg::RESP_LATCH;
    assign enable = en_cmd || en_pin || en_group;

    // event sources, reported whatever the response code
    assign ev[frsb_pkg::F_BUSY] = busy_evt;
    assign ev[frsb_pkg::F_VOUT_OV] = vout_ov_evt;
    assign ev[frsb_pkg::F_IOUT_OC] = iout_oc_evt;
    assign ev[frsb_pkg::F_VIN_UV] = vin_uv_evt;
    assign ev[frsb_pkg::F_TEMP] = temp_evt;
    assign ev[frsb_pkg::F_CML] = cml_evt || bad_data || (cmd_valid && !known);
    assign ev[frsb_pkg::F_OTHER] = other_evt;
    assign ev[frsb_pkg::F_VOUT_UV] = vout_uv_evt;
    assign ev[frsb_pkg::F_VOUT_MAX] = vout_max_evt;
    assign ev[frsb_pkg::F_POUT_OP] = op_over;
    assign ev[frsb_pkg::F_IOUT_WARN] = iout_warn_evt;
    assign ev[frsb_pkg::F_INPUT] = input_evt;
    assign ev[frsb_pkg::F_MFR] = mfr_evt;

    // clear masks from write-one-to-clear on the three status registers
    logic w_sum;
    logic w_ext;
    logic w_vo;
    logic [7:0] lo;
    assign w_sum = wr && (cmd_code == frsb_pkg::CMD_SUMMARY || cmd_code == frsb_pkg::CMD_EXTENDED);
    assign w_ext = wr && cmd_code == frsb_pkg::CMD_EXTENDED;
    assign w_vo = wr && cmd_code == frsb_pkg::CMD_VOUT_FLAGS;
    assign lo = w_sum ? cmd_wdata[7:0] : 8'h00;

    assign clr[frsb_pkg::F_BUSY] = lo[frsb_pkg::B_BUSY];
    assign clr[frsb_pkg::F_VOUT_OV] = lo[frsb_pkg::B_VOUT_OV]
        || (w_ext && cmd_wdata[frsb_pkg::BW_VOUT]) || (w_vo && cmd_wdata[frsb_pkg::BV_OV]);
    assign clr[frsb_pkg::F_IOUT_OC] = lo[frsb_pkg::B_IOUT_OC]
        || (w_ext && cmd_wdata[frsb_pkg::BW_IOUT]);
    assign clr[frsb_pkg::F_VIN_UV] = lo[frsb_pkg::B_VIN_UV]
        || (w_ext && cmd_wdata[frsb_pkg::BW_INPUT]);
    assign clr[frsb_pkg::F_TEMP] = lo[frsb_pkg::B_TEMP];
    assign clr[frsb_pkg::F_CML] = lo[frsb_pkg::B_CML];
    assign clr[frsb_pkg::F_OTHER] = lo[frsb_pkg::B_OTHER];
    assign clr[frsb_pkg::F_VOUT_UV] = (w_ext && cmd_wdata[frsb_pkg::BW_VOUT])
        || (w_vo && cmd_wdata[frsb_pkg::BV_UV]);
    assign clr[frsb_pkg::F_VOUT_MAX] = (w_ext && cmd_wdata[frsb_pkg::BW_VOUT])
        || (w_vo && cmd_wdata[frsb_pkg::BV_MAX]);
    assign clr[frsb_pkg::F_POUT_OP] = (w_ext && cmd_wdata[frsb_pkg::BW_IOUT]) || lo[frsb_pkg::B_OTHER];
    assign clr[frsb_pkg::F_IOUT_WARN] = (w_ext && cmd_wdata[frsb_pkg::BW_IOUT])
        || lo[frsb_pkg::B_OTHER];
    assign clr[frsb_pkg::F_INPUT] = (w_ext && cmd_wdata[frsb_pkg::BW_INPUT]) || lo[frsb_pkg::B_OTHER];
    assign clr[frsb_pkg::F_MFR] = (w_ext && cmd_wdata[frsb_pkg::BW_MFR]) || lo[frsb_pkg::B_OTHER];

    // sticky flags: a new event in the clearing cycle wins over the clear
    genvar gi;
    generate
        for (gi = 0; gi < frsb_pkg::NFLAG; gi++) begin : g_flag
            assign flag_nx[gi] = ev[gi] || (q.flags[gi] && !clr[gi]);
        end
    endgenerate

    // status views, all active high
    always_comb begin
        summary = 8'h00;
        summary[frsb_pkg::B_BUSY] = q.flags[frsb_pkg::F_BUSY];
        summary[frsb_pkg::B_OFF] = q.state != frsb_pkg::PWR_ON;
        summary[frsb_pkg::B_VOUT_OV] = q.flags[frsb_pkg::F_VOUT_OV];
        summary[frsb_pkg::B_IOUT_OC] = q.flags[frsb_pkg::F_IOUT_OC];
        summary[frsb_pkg::B_VIN_UV] = q.flags[frsb_pkg::F_VIN_UV];
        summary[frsb_pkg::B_TEMP] = q.flags[frsb_pkg::F_TEMP];
        summary[frsb_pkg::B_CML] = q.flags[frsb_pkg::F_CML];
        // everything without a summary bit of its own lands here
        summary[frsb_pkg::B_OTHER] = q.flags[frsb_pkg::F_OTHER] || q.flags[frsb_pkg::F_VOUT_UV]
            || q.flags[frsb_pkg::F_VOUT_MAX] || q.flags[frsb_pkg::F_POUT_OP]
            || q.flags[frsb_pkg::F_IOUT_WARN] || q.flags[frsb_pkg::F_INPUT]
            || q.flags[frsb_pkg::F_MFR];
        extended = {8'h00, summary};
        extended[frsb_pkg::BW_VOUT] = q.flags[frsb_pkg::F_VOUT_OV]
            || q.flags[frsb_pkg::F_VOUT_UV] || q.flags[frsb_pkg::F_VOUT_MAX];
        extended[frsb_pkg::BW_IOUT] = q.flags[frsb_pkg::F_IOUT_OC]
            || q.flags[frsb_pkg::F_IOUT_WARN] || q.flags[frsb_pkg::F_POUT_OP];
        extended[frsb_pkg::BW_INPUT] = q.flags[frsb_pkg::F_VIN_UV]
            || q.flags[frsb_pkg::F_INPUT];
        extended[frsb_pkg::BW_MFR] = q.flags[frsb_pkg::F_MFR];
        vflags = 8'h00;
        vflags[frsb_pkg::BV_OV] = q.flags[frsb_pkg::F_VOUT_OV];
        vflags[frsb_pkg::BV_UV] = q.flags[frsb_pkg::F_VOUT_UV];
        vflags[frsb_pkg::BV_MAX] = q.flags[frsb_pkg::F_VOUT_MAX];
    end

    // delay skipped only for a share member enabled by group alone; bus, pin or non-member group enable waits
    assign ton.run = q.state == frsb_pkg::PWR_WAIT;
    assign ton.steps = q.ton;
    assign ton.bypass = share_member && !en_cmd && !en_pin;

    frsb_ton_timer #(
        .STEP_CYC(TON_STEP_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .ton(ton)
    );

    // register writes, power sequencing and read answers
    always_comb begin
        d = q;
        d.flags = flag_nx;
        d.rsp_valid = rd;
        d.rdata = 16'h0000;
        if (wr && !bad_data) begin
            case (cmd_code)
                frsb_pkg::CMD_IN_UV_RESP: d.in_uv_resp = cmd_wdata[7:0];
                frsb_pkg::CMD_OP_RESP: d.op_resp = cmd_wdata[7:0];
                frsb_pkg::CMD_TURN_ON_DELAY: d.ton = cmd_wdata[7:0];
                frsb_pkg::CMD_OP_LIMIT: d.op_mant = cmd_wdata[9:0];
                default: d.ton = q.ton;
            endcase
        end
        if (rd) begin
            case (cmd_code)
                frsb_pkg::CMD_IN_UV_RESP: d.rdata = {8'h00, q.in_uv_resp};
                frsb_pkg::CMD_OP_RESP: d.rdata = {8'h00, q.op_resp};
                frsb_pkg::CMD_TURN_ON_DELAY: d.rdata = {8'h00, q.ton};
                frsb_pkg::CMD_OP_LIMIT: d.rdata = {frsb_pkg::OP_EXP_VAL, 1'b0, q.op_mant};
                frsb_pkg::CMD_SUMMARY: d.rdata = {8'h00, summary};
                frsb_pkg::CMD_EXTENDED: d.rdata = extended;
                frsb_pkg::CMD_VOUT_FLAGS: d.rdata = {8'h00, vflags};
                default: d.rdata = 16'h0000;
            endcase
        end
        // latched shutdown needs the cause cleared and the enable cycled
        case (q.state)
            frsb_pkg::PWR_OFF: begin
                if (enable) begin
                    d.state = frsb_pkg::PWR_WAIT;
                end
            end
            frsb_pkg::PWR_WAIT: begin
                if (uv_trip || op_trip) begin
                    d.state = frsb_pkg::PWR_TRIP;
                end else if (!enable) begin
                    d.state = frsb_pkg::PWR_OFF;
                end else if (ton.done) begin
                    d.state = frsb_pkg::PWR_ON;
                end
            end
            frsb_pkg::PWR_ON: begin
                if (uv_trip || op_trip) begin
                    d.state = frsb_pkg::PWR_TRIP;
                end else if (!enable) begin
                    d.state = frsb_pkg::PWR_OFF;
                end
            end
            frsb_pkg::PWR_TRIP: begin
                if (!enable && !q.flags[frsb_pkg::F_VIN_UV] && !q.flags[frsb_pkg::F_POUT_OP]) begin
                    d.state = frsb_pkg::PWR_OFF;
                end
            end
            default: d.state = frsb_pkg::PWR_OFF;
        endcase
        d.vout_en = d.state == frsb_pkg::PWR_ON;
        // alert is open drain: drive low while any flag stands
        d.alert_o = 1'b0;
        d.alert_oe = |flag_nx;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.in_uv_resp <= frsb_pkg::RST_IN_UV_RESP;
            q.op_resp <= frsb_pkg::RST_OP_RESP;
            q.ton <= frsb_pkg::RST_TON;
            q.op_mant <= frsb_pkg::RST_OP_MANT;
            q.state <= frsb_pkg::PWR_OFF;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign rsp_valid = q.rsp_valid;
    assign rsp_rdata = q.rdata;
    assign vout_enable = q.vout_en;
    assign fault_alert_line_o = q.alert_o;
    assign fault_alert_line_oe = q.alert_oe;
endmodule

// ### dv/frsb_top_assertions.sv
// Purpose: port checks for the fault response and status bank
// Assumes: one clock, synchronous active-high reset
// Notes: alert may lag a clear by a cycle, so stickiness skips two cycles
module frsb_top_assertions #(
    parameter int TON_STEP_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic en_cmd,
    input wire logic en_pin,
    input wire logic en_group,
    input wire logic vin_uv_evt,
    input wire logic temp_evt,
    input wire logic vout_enable,
    input wire logic fault_alert_line_o,
    input wire logic fault_alert_line_oe
);
    logic en_any;
    logic wr_now;
    // any enable source, any host write
    assign en_any = en_cmd || en_pin || en_group;
    assign wr_now = cmd_valid && cmd_write;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // off bit only judged while the output has been steady
    property p_off;
        rsp_valid && $past(cmd_code == 8'h78) && $stable(vout_enable)
            && $past(vout_enable, 2) == vout_enable |-> rsp_rdata[6] == !vout_enable;
    endproperty
    AST_READ_ANSWER: assert property (cmd_valid && !cmd_write |=> rsp_valid)
        else $error("read not answered");
    AST_ANSWER_CAUSE: assert property (rsp_valid |-> $past(cmd_valid && !cmd_write))
        else $error("answer without read");
    AST_RDATA_QUIET: assert property (!rsp_valid |-> rsp_rdata == 16'h0000)
        else $error("read data outside answer");
    AST_OFF_BIT: assert property (p_off)
        else $error("off bit wrong");
    AST_ALERT_LOW: assert property (fault_alert_line_oe |-> !fault_alert_line_o)
        else $error("alert not pulled low");
    AST_EVT_ALERT: assert property (vin_uv_evt || temp_evt |=> fault_alert_line_oe)
        else $error("fault without alert");
    AST_FLAG_STICKY: assert property (fault_alert_line_oe && !wr_now && !$past(wr_now) |=> fault_alert_line_oe)
        else $error("alert dropped without clear");
    AST_EN_DROP: assert property (!en_any |=> !vout_enable)
        else $error("output on without enable");
    AST_ON_CAUSE: assert property ($rose(vout_enable) |-> $past(en_any))
        else $error("output rose without enable");
    cover property (cmd_valid && !cmd_write && cmd_code == 8'h79);
    cover property ($rose(vout_enable));
    cover property ($fell(vout_enable) && en_cmd);
endmodule

bind frsb_top frsb_top_assertions #(.TON_STEP_CYCLES(TON_STEP_CYCLES)) u_frsb_chk (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .en_cmd(en_cmd), .en_pin(en_pin),
    .en_group(en_group), .vin_uv_evt(vin_uv_evt), .temp_evt(temp_evt),
    .vout_enable(vout_enable), .fault_alert_line_o(fault_alert_line_o),
    .fault_alert_line_oe(fault_alert_line_oe)
);

// ### dv/frsb_host_model.sv
// Purpose: host side of the decoded command port
// Assumes: tasks entered 10 ns after a rising edge
// Notes: valid stays up between back-to-back transfers until idle
module frsb_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet port from time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // one transfer, answer taken in the cycle after the taking edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk);
        #10;
        q = rsp_valid ? rsp_rdata : 16'hdead;
    endtask
    // stale code and data are scrambled so the design cannot lean on them
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
        @(posedge clk);
        #10;
    endtask
    // limit word always carries the fixed exponent, four watts a step
    function automatic logic [15:0] limit_word(input logic [9:0] m);
        return {frsb_pkg::OP_EXP_VAL, 1'b0, m};
    endfunction
endmodule

// ### dv/frsb_top_tb.sv
// Purpose: self-checking bench of the fault response and status bank
// Assumes: four clock cycles per turn-on delay step
// Notes: status flags are cleared by writing ones between cases
module frsb_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] c; logic [15:0] d; logic [15:0] e;} frsb_row_s;
    logic clk, rst, cmd_valid, cmd_write, rsp_valid, en_cmd, en_pin, en_group, share_member;
    logic vout_enable, alert_o, alert_oe;
    logic [7:0] cmd_code;
    logic [11:0] pout_watts, evt;
    logic [15:0] cmd_wdata, rsp_rdata, q;
    int error_cnt = 0;
    int num_checks = 0;
    frsb_row_s rows [12] = '{'{8'h5a, 16'h0000, 16'h0000}, '{8'h5a, 16'h0080, 16'h0080},
        '{8'h5a, 16'h0040, 16'h0080}, '{8'h69, 16'h0000, 16'h0000}, '{8'h69, 16'h00c0, 16'h0000},
        '{8'h69, 16'h0080, 16'h0080}, '{8'h60, 16'h00ff, 16'h00ff}, '{8'h60, 16'h0001, 16'h0001},
        '{8'h68, 16'h1000, 16'h1000}, '{8'h68, 16'h0805, 16'h1000}, '{8'h68, 16'h17ff, 16'h13ff},
        '{8'h6a, 16'h0001, 16'h0000}};
    logic [15:0] ew [12] = '{16'h00c0, 16'h8060, 16'h8041, 16'h8041, 16'h4050, 16'h4041,
        16'h2048, 16'h2041, 16'h0044, 16'h0042, 16'h1041, 16'h0041};
    logic [7:0] ev [12] = '{8'h00, 8'h80, 8'h10, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};

    frsb_top #(.TON_STEP_CYCLES(4)) i_dut (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .en_cmd(en_cmd),
        .en_pin(en_pin), .en_group(en_group), .share_member(share_member),
        .pout_watts(pout_watts), .busy_evt(evt[0]), .vout_ov_evt(evt[1]), .vout_uv_evt(evt[2]),
        .vout_max_evt(evt[3]), .iout_oc_evt(evt[4]), .iout_warn_evt(evt[5]),
        .vin_uv_evt(evt[6]), .input_evt(evt[7]), .temp_evt(evt[8]), .cml_evt(evt[9]),
        .mfr_evt(evt[10]), .other_evt(evt[11]), .vout_enable(vout_enable),
        .fault_alert_line_o(alert_o), .fault_alert_line_oe(alert_oe));
    frsb_host_model i_host (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_host.xfer(1'b1, c, d, q);
        i_host.idle();
    endtask
    task automatic rc(input logic [7:0] c, input logic [15:0] e);
        i_host.xfer(1'b0, c, 16'h0000, q);
        i_host.idle();
        check(q, e);
    endtask
    task automatic clr();
        wr(8'h79, 16'hffff);
        wr(8'h7a, 16'h00ff);
        cyc(1);
    endtask
    // waits for the output, bounded, then turns it off again
    task automatic ton_case(input logic [2:0] e, input logic s, input int lo, input int hi);
        int n = 0;
        share_member = s;
        {en_cmd, en_pin, en_group} = e;
        while (vout_enable !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        check(16'(n >= lo && n <= hi), 16'h0001);
        rc(8'h78, 16'h0000);
        {en_cmd, en_pin, en_group} = 3'b000;
        cyc(2);
        check(16'(vout_enable), 16'h0000);
    endtask

    // hang guard, far beyond the expected run
    initial begin
        #500000;
        error_cnt++;
        complete_run();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        {en_cmd, en_pin, en_group, share_member} = 4'h0;
        pout_watts = 12'h000;
        evt = 12'h000;
        cyc(5);
        rst = 1'b0;
        // write then read back to back
        foreach (rows[i]) begin
            i_host.xfer(1'b1, rows[i].c, rows[i].d, q);
            i_host.xfer(1'b0, rows[i].c, 16'h0000, q);
            i_host.idle();
            check(q, rows[i].e);
        end
        rc(8'h78, 16'h0042);
        clr();
        // each event alone: alert, grouping, stickiness, clear
        for (int i = 0; i < 12; i++) begin
            evt = 12'h001 << i;
            cyc(1);
            evt = 12'h000;
            cyc(1);
            check({14'h0000, alert_o, alert_oe}, 16'h0001);
            rc(8'h79, ew[i]);
            rc(8'h78, {8'h00, ew[i][7:0]});
            rc(8'h7a, {8'h00, ev[i]});
            clr();
            check(16'(alert_oe), 16'h0000);
        end
        wr(8'h60, 16'h0003);
        ton_case(3'b100, 1'b0, 12, 16);
        ton_case(3'b010, 1'b1, 12, 16);
        ton_case(3'b001, 1'b1, 0, 4);
        ton_case(3'b001, 1'b0, 12, 16);
        // over-power: boundary, latch, re-enable, ignore
        wr(8'h60, 16'h0000);
        wr(8'h68, i_host.limit_word(10'h010));
        en_cmd = 1'b1;
        cyc(6);
        pout_watts = 12'd64;
        cyc(2);
        check({14'h0000, vout_enable, alert_oe}, 16'h0002);
        pout_watts = 12'd65;
        cyc(2);
        pout_watts = 12'd0;
        cyc(3);
        check(16'(vout_enable), 16'h0000);
        rc(8'h79, 16'h4041);
        clr();
        cyc(2);
        check(16'(vout_enable), 16'h0000);
        en_cmd = 1'b0;
        cyc(2);
        en_cmd = 1'b1;
        cyc(6);
        check(16'(vout_enable), 16'h0001);
        wr(8'h69, 16'h0000);
        pout_watts = 12'd65;
        cyc(3);
        check({14'h0000, vout_enable, alert_oe}, 16'h0003);
        pout_watts = 12'd0;
        evt = 12'h040;
        cyc(1);
        evt = 12'h000;
        cyc(2);
        check(16'(vout_enable), 16'h0000);
        // second reset in mid-run restores the register defaults
        en_cmd = 1'b0;
        rst = 1'b1;
        cyc(5);
        rst = 1'b0;
        rc(8'h5a, 16'h0080);
        rc(8'h69, 16'h0080);
        rc(8'h60, 16'h0000);
        rc(8'h68, 16'h13ff);
        rc(8'h79, 16'h0040);
        check(16'(alert_oe), 16'h0000);
        complete_run();
    end
endmodule
